// *** include/pwmct_regs.svh ***
// register map, field positions, reset values and timing counts of the pwm timer
// assumes a 32-bit apb bus; each 16-bit register sits in the low half of one word
`ifndef PWMCT_REGS_SVH
`define PWMCT_REGS_SVH

// register indices; byte address is four times the index
`define PWMCT_IDX_CA 16'h5300
`define PWMCT_IDX_CB 16'h5302
`define PWMCT_IDX_TC 16'h5304
`define PWMCT_IDX_CTL 16'h5306
`define PWMCT_IDX_CLK 16'h5308
`define PWMCT_IDX_IMSK 16'h530a
`define PWMCT_IDX_IFLG 16'h530c

// control register fields
`define PWMCT_CTL_RUN 0
`define PWMCT_CTL_RST 1
`define PWMCT_CTL_OUTPUT_ENABLE 2
`define PWMCT_CTL_EXT 3
`define PWMCT_CTL_INV 4
`define PWMCT_CTL_CBUF 5
`define PWMCT_CTL_FINE 6
`define PWMCT_CTL_INIT 8
`define PWMCT_CTL_WMASK 16'h017d

// interrupt flag and mask fields
`define PWMCT_IRQ_CA 0
`define PWMCT_IRQ_CB 1

// reset values
`define PWMCT_RST_CMP 16'h0000
`define PWMCT_RST_CTL 16'h0000
`define PWMCT_RST_DIV 4'h0
`define PWMCT_RST_IRQ 2'h0

// prescaler: largest division exponent, select code that gives no clock
`define PWMCT_DIV_MAX 4'he
`define PWMCT_DIV_NONE 4'hf

`endif

// *** include/pwmct_pkg.sv ***
// types shared by the pwm timer modules
// assumes pwmct_regs.svh supplies the numeric constants
package pwmct_pkg;

    // which way an output-level change goes
    typedef enum logic [1:0] {
        PWMCT_EV_NONE = 2'b00,
        PWMCT_EV_ON = 2'b01,
        PWMCT_EV_OFF = 2'b11
    } pwmct_ev_t;

    typedef logic [15:0] pwmct_word_t;

endpackage

// *** rtl/pwmct_prescaler.sv ***
// count clock source of the pwm timer: internal prescaler or external event input
// assumes ext_clock_in is already synchronous to clock_in
`timescale 1ns/1ps
`default_nettype none
`include "pwmct_regs.svh"
module pwmct_prescaler #(
    parameter int DIV_W = 15
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic sel_ext_in,
    input wire logic [3:0] div_sel_in,
    input wire logic ext_clock_in,
    output logic rise_out,
    output logic fall_out
);
    initial begin
        if (DIV_W < 15) begin
            $error("pwmct_prescaler: DIV_W must be at least 15");
        end
    end

    logic [DIV_W-1:0] div_r;
    logic ext_prev_r;
    wire [14:0] mask = (15'h1 << div_sel_in) - 15'h1;
    wire [14:0] half = mask ^ (mask >> 1);
    wire [14:0] phase = div_r[14:0] & mask;
    wire div_ok = div_sel_in <= `PWMCT_DIV_MAX;
    wire int_rise = div_ok && (phase == 15'h0);
    // with division by one both edges fall into the same cycle
    wire int_fall = div_ok && (phase == half);
    wire ext_rise = ext_clock_in && !ext_prev_r;
    wire ext_fall = !ext_clock_in && ext_prev_r;

    // free-running divider, so run/stop never shifts the prescaler phase
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_r <= '0;
            ext_prev_r <= 1'b0;
        end else begin
            div_r <= div_r + DIV_W'(1);
            ext_prev_r <= ext_clock_in;
        end
    end

    // source select
    assign rise_out = sel_ext_in ? ext_rise : int_rise; // [RULE15]
    assign fall_out = sel_ext_in ? ext_fall : int_fall;

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    ext_event_a: assert property (sel_ext_in && $rose(ext_clock_in) |-> rise_out) // [RULE15]
        else $error("external rising edge gave no count tick");
    int_tick_a: assert property (!sel_ext_in && div_sel_in == 4'h0 |-> rise_out) // [RULE15]
        else $error("divide-by-one gave no tick");
    cover property (sel_ext_in && rise_out);
endmodule
`default_nettype wire

// *** rtl/pwmct_top.sv ***
// pwm timer: apb register file, 16-bit up counter, compare a/b, output pin, interrupt
// assumes apb master and ext_clock_in synchronous to clock_in; zero-wait slave
//
// Function
// [RULE1] each register 16 bits, own address
// [RULE2] software writes zero to reserved bits
// [RULE3] buffer off: compare access hits active
// [RULE4] buffer on: shadows load at counter reset
// [RULE5] a match: flag, output active, keep counting (flag is set only while its imask_r bit is set)
// [RULE6] b match: flag, counter back to zero (flag is set only while its imask_r bit is set)
// [RULE7] counter reads current count, write loads
// [RULE8] output off or reset: initial level
// [RULE9] invert bit inverts initial level
// [RULE10] fine mode: half-cycle duty steps
// [RULE11] compares 16 bits, reset zero, continuous
// [RULE12] reset bit clears counter, reads zero
// [RULE13] run counts, stop holds count
// [RULE14] invert selects active low output
// [RULE15] clock select: prescaler or external
// [RULE16] b match returns output off
// [RULE17] counter increments on selected clock edge
`timescale 1ns/1ps
`default_nettype none
`include "pwmct_regs.svh"
module pwmct_top
    import pwmct_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic ext_clock_in,
    output logic timer_output_pin_out,
    output logic irq_out
);
    initial begin
        if (ADDR_W < 17) begin
            $error("pwmct_top: ADDR_W must be at least 17");
        end
    end

    // byte-lane merge of a 16-bit register
    function automatic pwmct_word_t merge16(pwmct_word_t old, pwmct_word_t wd,
                                            logic [1:0] strb);
        merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    endfunction

    // word-aligned index match
    function automatic logic hit(logic [ADDR_W-1:0] addr, logic [15:0] idx);
        hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    pwmct_word_t ca_r, cb_r, cabuf_r, cbbuf_r, cnt_r, ctl_r;
    pwmct_word_t ca_nxt, cb_nxt, cabuf_nxt, cbbuf_nxt, cnt_nxt, ctl_nxt;
    logic [3:0] div_r;
    logic [1:0] imask_r, iflag_r, iflag_nxt;
    logic act_r, act_nxt, pend_r, pend_nxt, pin_r;
    pwmct_ev_t ev;

    // address decode, one hit per register [RULE1]
    wire sel_ca = hit(paddr_in, `PWMCT_IDX_CA);
    wire sel_cb = hit(paddr_in, `PWMCT_IDX_CB);
    wire sel_tc = hit(paddr_in, `PWMCT_IDX_TC);
    wire sel_ctl = hit(paddr_in, `PWMCT_IDX_CTL);
    wire sel_clk = hit(paddr_in, `PWMCT_IDX_CLK);
    wire sel_imsk = hit(paddr_in, `PWMCT_IDX_IMSK);
    wire sel_iflg = hit(paddr_in, `PWMCT_IDX_IFLG);
    wire mapped = sel_ca | sel_cb | sel_tc | sel_ctl | sel_clk | sel_imsk | sel_iflg;
    wire access = psel_in && penable_in;
    wire wr = access && pwrite_in && mapped;
    wire [15:0] wd = pwdata_in[15:0];
    wire [1:0] ws = pstrb_in[1:0];

    // control fields
    wire c_run = ctl_r[`PWMCT_CTL_RUN];
    wire c_output_enable = ctl_r[`PWMCT_CTL_OUTPUT_ENABLE];
    wire c_ext = ctl_r[`PWMCT_CTL_EXT];
    wire c_inv = ctl_r[`PWMCT_CTL_INV];
    wire c_cbuf = ctl_r[`PWMCT_CTL_CBUF];
    wire c_fine = ctl_r[`PWMCT_CTL_FINE];
    wire c_init = ctl_r[`PWMCT_CTL_INIT];

    wire wr_ca = wr && sel_ca;
    wire wr_cb = wr && sel_cb;
    wire wr_tc = wr && sel_tc;
    wire wr_ctl = wr && sel_ctl;
    // the reset bit is a strobe, never stored [RULE12]
    wire sw_rst = wr_ctl && ws[0] && wd[`PWMCT_CTL_RST];

    // apb answer: always ready, error on unmapped or misaligned address [RULE1]
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // read mux; buffered compare reads show the shadow [RULE3] [RULE4]
    wire [15:0] rd_ca = c_cbuf ? cabuf_r : ca_r;
    wire [15:0] rd_cb = c_cbuf ? cbbuf_r : cb_r;
    wire [15:0] rd16 = sel_ca ? rd_ca :
                       sel_cb ? rd_cb :
                       sel_tc ? cnt_r :
                       sel_ctl ? ctl_r :
                       sel_clk ? {12'h000, div_r} :
                       sel_imsk ? {14'h0000, imask_r} :
                       sel_iflg ? {14'h0000, iflag_r} : 16'h0000;
    assign prdata_out = {16'h0000, rd16};

    // count clock edges from the prescaler or the external input
    logic tick_rise, tick_fall;
    pwmct_prescaler #(
        .DIV_W(15)
    ) u_presc (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .sel_ext_in(c_ext),
        .div_sel_in(div_r),
        .ext_clock_in(ext_clock_in),
        .rise_out(tick_rise),
        .fall_out(tick_fall)
    );

    // compare logic, gated by run; a stopped timer sees no match [RULE11] [RULE13]
    wire cnt_tick = c_run && tick_rise;
    wire match_b = cnt_tick && (cnt_r == cb_r);
    // fine mode compares a[15:1] with the low 15 count bits [RULE10]
    wire eq_a = c_fine ? (cnt_r[14:0] == ca_r[15:1]) : (cnt_r == ca_r);
    wire match_a = cnt_tick && eq_a;
    wire a_late = match_a && c_fine && ca_r[0];
    wire a_now = match_a && !a_late;
    wire cnt_reload = sw_rst || match_b;

    // counter next value; software write beats counting [RULE7] [RULE12] [RULE13]
    always_comb begin
        cnt_nxt = cnt_r;
        if (sw_rst) begin
            cnt_nxt = 16'h0000; // [RULE12]
        end else if (wr_tc) begin
            cnt_nxt = merge16(cnt_r, wd, ws); // [RULE7]
        end else if (match_b) begin
            cnt_nxt = 16'h0000; // [RULE6]
        end else if (cnt_tick) begin
            cnt_nxt = cnt_r + 16'h0001; // [RULE17]
        end
    end

    // compare registers: direct or through shadows [RULE3] [RULE4]
    always_comb begin
        cabuf_nxt = (wr_ca && c_cbuf) ? merge16(cabuf_r, wd, ws) : cabuf_r;
        cbbuf_nxt = (wr_cb && c_cbuf) ? merge16(cbbuf_r, wd, ws) : cbbuf_r;
        ca_nxt = ca_r;
        cb_nxt = cb_r;
        if (c_cbuf && cnt_reload) begin
            ca_nxt = cabuf_nxt; // [RULE4]
            cb_nxt = cbbuf_nxt;
        end
        if (wr_ca && !c_cbuf) begin
            ca_nxt = merge16(ca_r, wd, ws); // [RULE3]
        end
        if (wr_cb && !c_cbuf) begin
            cb_nxt = merge16(cb_r, wd, ws);
        end
    end

    // reserved control bits are dropped so they always read zero
    assign ctl_nxt = wr_ctl ? (merge16(ctl_r, wd, ws) & `PWMCT_CTL_WMASK) : ctl_r;

    // output level events; b match wins over a match
    always_comb begin
        ev = PWMCT_EV_NONE;
        if (match_b) begin
            ev = PWMCT_EV_OFF; // [RULE16]
        end else if (a_now || (pend_r && tick_fall)) begin
            ev = PWMCT_EV_ON; // [RULE5] [RULE10]
        end
    end

    // active state: disabled or reset output shows the initial level [RULE8]
    always_comb begin
        act_nxt = act_r;
        pend_nxt = pend_r;
        if (!ctl_nxt[`PWMCT_CTL_OUTPUT_ENABLE] || sw_rst) begin
            act_nxt = ctl_nxt[`PWMCT_CTL_INIT]; // [RULE8]
            pend_nxt = 1'b0;
        end else begin
            if (ev == PWMCT_EV_OFF) begin
                act_nxt = 1'b0;
            end else if (ev == PWMCT_EV_ON) begin
                act_nxt = 1'b1;
            end
            // odd a in fine mode defers the edge to the next falling clock [RULE10]
            if (match_b) begin
                pend_nxt = 1'b0;
            end else if (a_late) begin
                pend_nxt = 1'b1;
            end else if (tick_fall) begin
                pend_nxt = 1'b0;
            end
        end
    end

    // event flags: set wins over a write-one clear [RULE5] [RULE6]
    wire [1:0] ev_set = {match_b, match_a} & imask_r;
    wire [1:0] clr = (wr && sel_iflg && ws[0]) ? wd[1:0] : 2'b00;
    assign iflag_nxt = (iflag_r & ~clr) | ev_set;
    assign irq_out = |(iflag_r & imask_r);

    // register update
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ca_r <= `PWMCT_RST_CMP; // [RULE11]
            cb_r <= `PWMCT_RST_CMP;
            cabuf_r <= `PWMCT_RST_CMP;
            cbbuf_r <= `PWMCT_RST_CMP;
            cnt_r <= `PWMCT_RST_CMP;
            ctl_r <= `PWMCT_RST_CTL;
        end else begin
            ca_r <= ca_nxt;
            cb_r <= cb_nxt;
            cabuf_r <= cabuf_nxt;
            cbbuf_r <= cbbuf_nxt;
            cnt_r <= cnt_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    // small registers and the pin; pin xor keeps invert live on both levels
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_r <= `PWMCT_RST_DIV;
            imask_r <= `PWMCT_RST_IRQ;
            iflag_r <= `PWMCT_RST_IRQ;
            act_r <= 1'b0;
            pend_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            div_r <= (wr && sel_clk && ws[0]) ? wd[3:0] : div_r;
            imask_r <= (wr && sel_imsk && ws[0]) ? wd[1:0] : imask_r;
            iflag_r <= iflag_nxt;
            act_r <= act_nxt;
            pend_r <= pend_nxt;
            pin_r <= act_nxt ^ ctl_nxt[`PWMCT_CTL_INV]; // [RULE9] [RULE14]
        end
    end
    assign timer_output_pin_out = pin_r;

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    bad_addr_a: assert property (psel_in && penable_in && paddr_in[1:0] != 2'b00 |-> pslverr_out) // [RULE1]
        else $error("misaligned access not refused");
    direct_ca_a: assert property (wr_ca && !c_cbuf && ws == 2'b11 |=> ca_r == $past(wd)) // [RULE3]
        else $error("direct compare a write lost");
    buf_load_a: assert property (c_cbuf && match_b && !wr_ca |=> ca_r == $past(cabuf_r)) // [RULE4]
        else $error("shadow not loaded at period end");
    a_active_a: assert property (c_output_enable && a_now && !match_b && !wr_ctl |=> pin_r == !c_inv) // [RULE5]
        else $error("compare a did not drive active level");
    a_flag_a: assert property (match_a && imask_r[0] |=> iflag_r[0] ##0 irq_out) // [RULE5]
        else $error("compare a flag or interrupt missing");
    b_wrap_a: assert property (match_b && !sw_rst && !wr_tc |=> cnt_r == 16'h0000) // [RULE6]
        else $error("compare b did not clear counter");
    cnt_load_a: assert property (wr_tc && !sw_rst && ws == 2'b11 |=> cnt_r == $past(wd)) // [RULE7]
        else $error("counter write not loaded");
    off_level_a: assert property (!c_output_enable && !wr_ctl |=> pin_r == (c_init ^ c_inv)) // [RULE8]
        else $error("disabled pin not at initial level");
    rst_level_a: assert property (sw_rst |=> pin_r == ($past(ctl_nxt[8]) ^ c_inv)) // [RULE9]
        else $error("reset bit did not restore initial level");
    fine_half_a: assert property (c_output_enable && pend_r && tick_fall && !match_b && !wr_ctl
        |=> pin_r == !c_inv) // [RULE10]
        else $error("fine mode half-cycle edge missing");
    rst_zero_a: assert property (sw_rst |=> cnt_r == 16'h0000 && !ctl_r[1]) // [RULE12]
        else $error("reset bit did not clear counter");
    stop_hold_a: assert property (!c_run && !wr_tc && !sw_rst |=> $stable(cnt_r)) // [RULE13]
        else $error("stopped counter moved");
    b_off_a: assert property (c_output_enable && match_b && !wr_ctl |=> pin_r == c_inv) // [RULE16]
        else $error("compare b did not return off level");
    count_up_a: assert property (cnt_tick && !match_b && !wr_tc && !sw_rst
        |=> cnt_r == 16'($past(cnt_r) + 16'h0001)) // [RULE17]
        else $error("counter did not step by one");

    cover property (c_output_enable && a_now);
    cover property (c_cbuf && match_b);
    cover property (c_fine && a_late ##[1:40] pend_r && tick_fall);
    cover property (irq_out ##1 !irq_out);
endmodule
`default_nettype wire

// *** test/pwmct_far_model.sv ***
// far side of the pwm timer: load on the output pin and a level-trigger interrupt controller
// assumes pin and irq are launched from clock_in flip-flops or registers
`timescale 1ns/1ps
`default_nettype none
module pwmct_far_model (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic pin_in,
    input wire logic irq_in,
    input wire logic clear_in,
    output logic [15:0] rises_out,
    output logic [15:0] falls_out,
    output logic irq_seen_out
);
    logic pin_r;
    // edge counts on the pin; clear_in lets each test start from zero
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_r <= 1'b0;
            rises_out <= 16'h0000;
            falls_out <= 16'h0000;
        end else begin
            pin_r <= pin_in;
            rises_out <= clear_in ? 16'h0000 : rises_out + 16'(pin_in & ~pin_r);
            falls_out <= clear_in ? 16'h0000 : falls_out + 16'(~pin_in & pin_r);
        end
    end
    // level trigger: the flag follows a high request, only clear_in drops it
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_seen_out <= 1'b0;
        end else begin
            irq_seen_out <= irq_in | (irq_seen_out & ~clear_in);
        end
    end
endmodule
`default_nettype wire

// *** test/pwmct_top_tb_top.sv ***
// directed testbench of the pwm timer: apb master tasks and one task per scenario
// assumes the zero-wait apb slave of pwmct_top and the far model beside it
`timescale 1ns/1ps
`default_nettype none
`include "pwmct_regs.svh"
module pwmct_top_tb_top
    import pwmct_pkg::*;
;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [19:0] paddr = 20'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, pin, irq, seen;
    logic ext_clk = 1'b0;
    logic clr = 1'b0;
    logic [15:0] rises, falls;
    // low address bits of the next transfer; nonzero only to provoke a refusal
    logic [1:0] lowbits = 2'b00;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    pwmct_top dut_u (.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(4'h3), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ext_clock_in(ext_clk), .timer_output_pin_out(pin), .irq_out(irq));
    pwmct_far_model far_u (.clock_in(clock_in), .rstn_in(rstn_in), .pin_in(pin),
        .irq_in(irq), .clear_in(clr), .rises_out(rises), .falls_out(falls),
        .irq_seen_out(seen));

    // 125 MHz
    initial begin
        forever #4 clock_in = ~clock_in;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask

    // one apb transfer; request held until pready is sampled high, hang guard ends a stall
    task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d,
                       output logic [31:0] rdat, output logic err);
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, lowbits};
        pwdata <= {16'h0000, d};
        @(posedge clock_in);
        penable <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 16'h0000, r, e);
        chk(nm, exp, r);
    endtask

    task automatic t_reset();
        logic [15:0] map[7] = '{`PWMCT_IDX_CA, `PWMCT_IDX_CB, `PWMCT_IDX_TC,
            `PWMCT_IDX_CTL, `PWMCT_IDX_CLK, `PWMCT_IDX_IMSK, `PWMCT_IDX_IFLG};
        logic [31:0] r;
        logic e;
        foreach (map[i]) rchk("reset_value", map[i], 32'h00000000);
        apb(1'b0, 16'h530e, 16'h0000, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        lowbits = 2'b10;
        apb(1'b0, `PWMCT_IDX_CA, 16'h0000, r, e);
        lowbits = 2'b00;
        chk("misaligned_err", 32'h1, {31'h0, e});
        chk("pin_reset", 32'h0, {31'h0, pin});
        $display("t_reset done");
    endtask

    task automatic t_counter();
        logic [31:0] v1, v2;
        logic e;
        wr(`PWMCT_IDX_CB, 16'hffff);
        wr(`PWMCT_IDX_TC, 16'h1234);
        rchk("tc_load", `PWMCT_IDX_TC, 32'h1234);
        wr(`PWMCT_IDX_CTL, 16'h0001);
        repeat (10) @(posedge clock_in);
        wr(`PWMCT_IDX_CTL, 16'h0000);
        apb(1'b0, `PWMCT_IDX_TC, 16'h0000, v1, e);
        repeat (8) @(posedge clock_in);
        apb(1'b0, `PWMCT_IDX_TC, 16'h0000, v2, e);
        chk("tc_moved", 32'h1241, v1);
        chk("tc_held", v1, v2);
        wr(`PWMCT_IDX_CTL, 16'h0002);
        rchk("tc_cleared", `PWMCT_IDX_TC, 32'h0);
        rchk("rst_bit_reads", `PWMCT_IDX_CTL, 32'h0);
        $display("t_counter done");
    endtask

    task automatic t_ext();
        wr(`PWMCT_IDX_CTL, 16'h0009);
        repeat (6) begin
            @(posedge clock_in);
            ext_clk <= 1'b1;
            @(posedge clock_in);
            ext_clk <= 1'b0;
        end
        repeat (3) @(posedge clock_in);
        wr(`PWMCT_IDX_CTL, 16'h0000);
        rchk("ext_count", `PWMCT_IDX_TC, 32'h6);
        $display("t_ext done");
    endtask

    task automatic t_levels();
        for (int i = 0; i < 4; i++) begin
            wr(`PWMCT_IDX_CTL, {7'h0, i[1], 3'h0, i[0], 4'h0});
            repeat (2) @(posedge clock_in);
            chk("off_level", {31'h0, i[1] ^ i[0]}, {31'h0, pin});
        end
        $display("t_levels done");
    endtask

    task automatic t_pwm();
        logic [31:0] tc;
        logic e;
        wr(`PWMCT_IDX_CB, 16'h0004);
        wr(`PWMCT_IDX_CA, 16'h0002);
        wr(`PWMCT_IDX_IFLG, 16'h0003);
        wr(`PWMCT_IDX_IMSK, 16'h0003);
        wr(`PWMCT_IDX_TC, 16'h0000);
        clr <= 1'b1;
        @(posedge clock_in);
        clr <= 1'b0;
        wr(`PWMCT_IDX_CTL, 16'h0005);
        repeat (40) @(posedge clock_in);
        wr(`PWMCT_IDX_CTL, 16'h0000);
        chk("pin_rises", 32'h1, {31'h0, rises >= 16'd6});
        chk("pin_falls", 32'h1, {31'h0, falls >= 16'd6});
        rchk("flags_ab", `PWMCT_IDX_IFLG, 32'h3);
        chk("irq_level", 32'h1, {31'h0, irq});
        chk("itc_seen", 32'h1, {31'h0, seen});
        apb(1'b0, `PWMCT_IDX_TC, 16'h0000, tc, e);
        chk("tc_wraps", 32'h1, {31'h0, tc <= 32'h4});
        wr(`PWMCT_IDX_IFLG, 16'h0003);
        rchk("flags_clear", `PWMCT_IDX_IFLG, 32'h0);
        chk("irq_clear", 32'h0, {31'h0, irq});
        wr(`PWMCT_IDX_IMSK, 16'h0001);
        wr(`PWMCT_IDX_CTL, 16'h0005);
        repeat (20) @(posedge clock_in);
        wr(`PWMCT_IDX_CTL, 16'h0000);
        rchk("flag_masked", `PWMCT_IDX_IFLG, 32'h1);
        wr(`PWMCT_IDX_IMSK, 16'h0000);
        // the mask lands at the access edge; look once it has settled
        @(negedge clock_in);
        chk("irq_gated", 32'h0, {31'h0, irq});
        wr(`PWMCT_IDX_IFLG, 16'h0001);
        $display("t_pwm done");
    endtask

    task automatic t_buffer();
        wr(`PWMCT_IDX_CB, 16'h0007);
        rchk("cb_direct", `PWMCT_IDX_CB, 32'h7);
        wr(`PWMCT_IDX_CTL, 16'h0020);
        wr(`PWMCT_IDX_CA, 16'h0009);
        rchk("ca_shadow", `PWMCT_IDX_CA, 32'h9);
        wr(`PWMCT_IDX_CTL, 16'h0000);
        rchk("ca_active_kept", `PWMCT_IDX_CA, 32'h2);
        wr(`PWMCT_IDX_CTL, 16'h0020);
        wr(`PWMCT_IDX_CTL, 16'h0022);
        wr(`PWMCT_IDX_CTL, 16'h0000);
        rchk("ca_loaded", `PWMCT_IDX_CA, 32'h9);
        $display("t_buffer done");
    endtask

    // cycles with the pin high over eight periods of eight clocks (divide by two, b = 3)
    task automatic duty(input logic [15:0] ctl, input logic [15:0] ca, input logic [31:0] exp);
        logic [31:0] n;
        n = 32'h0;
        wr(`PWMCT_IDX_CTL, 16'h0000);
        wr(`PWMCT_IDX_CA, ca);
        wr(`PWMCT_IDX_TC, 16'h0000);
        wr(`PWMCT_IDX_CTL, ctl);
        // settle for three periods; the free prescaler phase then no longer matters
        repeat (24) @(posedge clock_in);
        repeat (64) begin
            @(posedge clock_in);
            if (pin === 1'b1) begin
                n = n + 32'h1;
            end
        end
        chk("duty_high", exp, n);
    endtask

    task automatic t_fine();
        wr(`PWMCT_IDX_CB, 16'h0003);
        wr(`PWMCT_IDX_CLK, 16'h0001);
        rchk("clk_sel", `PWMCT_IDX_CLK, 32'h1);
        duty(16'h0045, 16'h0003, 32'd24);
        duty(16'h0005, 16'h0002, 32'd16);
        duty(16'h0055, 16'h0003, 32'd40);
        wr(`PWMCT_IDX_CTL, 16'h0000);
        wr(`PWMCT_IDX_CLK, 16'h0000);
        $display("t_fine done");
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_reset();
        t_counter();
        t_ext();
        t_levels();
        t_pwm();
        t_buffer();
        t_fine();
        close_out();
    end
endmodule
`default_nettype wire
